// File: include/dtm_pkg.sv
package dtm_pkg;

  // Register offsets
  localparam logic [6:0] DTM_TEMP_ADDR    = 7'h06;
  localparam logic [6:0] DTM_SUPPRESS_ADDR = 7'h07;
  localparam logic [6:0] DTM_OFFA_ADDR    = 7'h08;
  localparam logic [6:0] DTM_OFFB_ADDR    = 7'h09;

  // Reset values
  localparam logic [15:0] DTM_SUPPRESS_RST = 16'hffff;
  localparam logic [12:0] DTM_OFF_RST      = 13'h0000;
  localparam logic [2:0]  DTM_FIFO_OFF_RST = 3'h4;
  localparam logic [15:0] DTM_MIDSCALE     = 16'h8000;
  localparam logic [15:0] DTM_WORD_RST     = 16'h0000;

  // Field layout
  localparam int DTM_TEMP_LSB  = 8;
  localparam int DTM_OFF_W     = 13;
  localparam int DTM_FOFF_LSB  = 13;

  // Writable bits of the suppression register (14, 6, 0 unused)
  localparam logic [15:0] DTM_SUPPRESS_USED = 16'hbfbe;

  // Serial clock constraint for the temperature read, in ns
  localparam int DTM_TEMP_SCLK_MIN_NS = 1000;
  localparam int DTM_CLK_NS           = 8;
  localparam int DTM_TEMP_SCLK_CYC    =
    (DTM_TEMP_SCLK_MIN_NS + DTM_CLK_NS - 1) / DTM_CLK_NS;

  // Register write request
  typedef struct packed {
    logic        wr;
    logic [6:0]  addr;
    logic [15:0] data;
  } dtm_wreq_type;

  // Alarm sources in suppression bit order
  typedef struct packed {
    logic zero_wptr;
    logic unused14;
    logic collision;
    logic pointer_one_apart_alarm;
    logic pointer_two_apart_alarm;
    logic conv_clk_gone;
    logic in_clk_gone;
    logic output_forced;
    logic pattern_mismatch;
    logic unused6;
    logic pll_unlock;
    logic parity_a;
    logic parity_b;
    logic parity_c;
    logic parity_d;
    logic unused0;
  } dtm_alarm_type;

endpackage

// File: hw/dtm_regs.sv
`timescale 1ns/1ps
// Summary of operation
// [R1] Temperature sensor result sits in bits 15:8, signed degrees Celsius.
// [R2] Host reads temperature with serial clock period of at least 1 us.
// [R3] Temperature register is read-only, no reset value, writes ignored.
// [R4] Sixteen suppression bits, 1 masks an alarm, all set after reset.
// [R5] Bit-to-alarm map fixed; bits 14, 6 and 0 unused.
// [R6] Channel A offset is 13 bits in 12:0, LSB units, reset zero.
// [R7] With auto-sync enabled, a channel A offset write raises a sync.
// [R8] Sync loads channel A and B offsets into correction in one cycle.
// [R9] Host writes channel B offset first, channel A offset last.
// [R10] Channel B offset write alone leaves the applied offset unchanged.
// [R11] Channel B offset in bits 12:0 of the next register, LSB units.
// [R12] Output-forced alarm high drives midscale on every channel output.
// [R13] Reserved bits read zero; writes to them have no effect. Unused suppression bits 14, 6 and 0 read 1 from reset until the first write.
module dtm_regs
(
  input  wire logic                   clock,
  input  wire logic                   rst_b,
  input  wire dtm_pkg::dtm_wreq_type  wreq,
  input  wire logic [6:0]             rd_addr,
  input  wire logic [7:0]             temp_sensor,
  input  wire logic                   auto_sync_en,
  input  wire dtm_pkg::dtm_alarm_type alarm_raw,
  output logic [15:0]                 rd_data,
  output logic [15:0]                 alarm_active,
  output logic                        output_forced,
  output logic [12:0]                 chan_a_offset_value,
  output logic [12:0]                 chan_b_offset_value,
  output logic                        offset_sync,
  output logic [2:0]                  fifo_offset
);
  import dtm_pkg::*;

  // Temperature capture: two synchroniser stages, a third stage to
  // compare against, and the sample that the host reads back
  logic [7:0]  temp_s1_r;
  logic [7:0]  temp_s2_r;
  logic [7:0]  temp_s3_r;
  logic [7:0]  temp_r;
  logic [7:0]  temp_nxt;

  // Host-visible configuration: suppression mask and staged offsets
  logic [15:0] suppress_r;
  logic [15:0] suppress_nxt;
  logic [12:0] off_a_r;
  logic [12:0] off_a_nxt;
  logic [12:0] off_b_r;
  logic [12:0] off_b_nxt;
  logic [2:0]  foff_r;
  logic [2:0]  foff_nxt;
  logic        sync_r;
  logic        sync_nxt;

  // Offsets as applied by the correction logic
  logic [12:0] app_a_r;
  logic [12:0] app_a_nxt;
  logic [12:0] app_b_r;
  logic [12:0] app_b_nxt;

  // Registered read data and gated alarm flags
  logic [15:0] rd_r;
  logic [15:0] rd_nxt;
  logic [15:0] act_r;
  logic [15:0] act_nxt;
  logic        force_r;
  logic        force_nxt;

  // Raw alarms as a flat word in suppression bit order
  logic [15:0] raw;

  // True when this cycle carries a write to the given register
  function automatic logic hit(input dtm_wreq_type q,
                               input logic [6:0]   a);
    hit = q.wr && (q.addr == a);
  endfunction

  // Offset field of a written word; both offset registers share it
  function automatic logic [12:0] offset_field(input logic [15:0] d);
    offset_field = d[DTM_OFF_W-1:0];
  endfunction

  assign raw = alarm_raw;

  // The sensor word is not gray coded, so a synchronised code is taken
  // only once it has stood still for a cycle; a half-changed word would
  // otherwise read back as a wild temperature
  always_comb
  begin
    temp_nxt = temp_r;
    if (temp_s2_r == temp_s3_r)
      temp_nxt = temp_s2_r;                             // [R1]
  end

  // No reset here: the readout has no defined value until the sensor
  // word has passed the stages, a few cycles after power-up
  always_ff @(posedge clock)
  begin
    temp_s1_r <= temp_sensor;
    temp_s2_r <= temp_s1_r;
    temp_s3_r <= temp_s2_r;
    temp_r    <= temp_nxt;                              // [R3]
  end

  // Register writes; the temperature address is not decoded here, so
  // it stays read-only and a write to it is dropped
  // Unused suppression bits and offset-A upper bits never store
  always_comb
  begin
    suppress_nxt = suppress_r;
    off_a_nxt    = off_a_r;
    off_b_nxt    = off_b_r;
    foff_nxt     = foff_r;
    sync_nxt     = 1'b0;
    if (hit(wreq, DTM_SUPPRESS_ADDR))
      suppress_nxt = wreq.data & DTM_SUPPRESS_USED;     // [R4] [R5] [R13]
    if (hit(wreq, DTM_OFFA_ADDR))
    begin
      off_a_nxt = offset_field(wreq.data);              // [R6] [R13]
      sync_nxt  = auto_sync_en;                         // [R7]
    end
    if (hit(wreq, DTM_OFFB_ADDR))
    begin
      off_b_nxt = offset_field(wreq.data);              // [R10] [R11]
      foff_nxt  = wreq.data[15:DTM_FOFF_LSB];
    end
  end

  // Configuration registers
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      suppress_r <= DTM_SUPPRESS_RST;                   // [R4]
      off_a_r    <= DTM_OFF_RST;                        // [R6]
      off_b_r    <= DTM_OFF_RST;                        // [R11]
      foff_r     <= DTM_FIFO_OFF_RST;
      sync_r     <= 1'b0;
    end
    else
    begin
      suppress_r <= suppress_nxt;
      off_a_r    <= off_a_nxt;
      off_b_r    <= off_b_nxt;
      foff_r     <= foff_nxt;
      sync_r     <= sync_nxt;                           // [R7]
    end
  end

  // The load runs one cycle after the A write, from the registers
  // rather than the bus, so A and B switch on the same edge
  // Limitation: a B write in the same cycle as the load lands only on
  // the next load; the host must finish B before writing A
  always_comb
  begin
    app_a_nxt = app_a_r;
    app_b_nxt = app_b_r;
    if (sync_r)
    begin
      app_a_nxt = off_a_r;                              // [R8]
      app_b_nxt = off_b_r;                              // [R8] [R10]
    end
  end

  // Applied offsets; reset to zero correction on both channels
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      app_a_r <= DTM_OFF_RST;
      app_b_r <= DTM_OFF_RST;
    end
    else
    begin
      app_a_r <= app_a_nxt;                             // [R8]
      app_b_r <= app_b_nxt;                             // [R8]
    end
  end

  // Read mux and alarm gating, both registered so every output leaves
  // a flop; the price is one cycle of read latency
  always_comb
  begin
    case (rd_addr)
      DTM_TEMP_ADDR:     rd_nxt = {temp_r, 8'h00};      // [R1] [R13]
      DTM_SUPPRESS_ADDR: rd_nxt = suppress_r;           // [R4]
      DTM_OFFA_ADDR:     rd_nxt = {3'h0, off_a_r};      // [R6] [R13]
      DTM_OFFB_ADDR:     rd_nxt = {foff_r, off_b_r};    // [R11]
      default:           rd_nxt = DTM_WORD_RST;         // [R13]
    endcase
    act_nxt   = raw & ~suppress_r & DTM_SUPPRESS_USED;  // [R4] [R5]
    force_nxt = alarm_raw.output_forced;                // [R12]
  end

  // Read and alarm registers
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rd_r    <= DTM_WORD_RST;
      act_r   <= DTM_WORD_RST;
      force_r <= 1'b0;
    end
    else
    begin
      rd_r    <= rd_nxt;
      act_r   <= act_nxt;
      force_r <= force_nxt;
    end
  end

  // Outputs straight from the flops; the datapath drives midscale on
  // every converter channel while output_forced is high, and it is not
  // masked, since suppressing it must not release a forced output
  assign rd_data             = rd_r;
  assign alarm_active        = act_r;
  assign output_forced       = force_r;                 // [R12]
  assign chan_a_offset_value = app_a_r;
  assign chan_b_offset_value = app_b_r;
  assign offset_sync         = sync_r;
  assign fifo_offset         = foff_r;
endmodule

// File: bench/dtm_regs_monitor.sv
`timescale 1ns/1ps
// Watches the register block from its pins only
module dtm_regs_monitor
  import dtm_pkg::*;
(
  input wire logic          clock,
  input wire logic          rst_b,
  input wire logic          auto_sync_en,
  input wire logic          offset_sync,
  input wire logic          output_forced,
  input wire dtm_wreq_type  wreq,
  input wire dtm_alarm_type alarm_raw,
  input wire logic [6:0]    rd_addr,
  input wire logic [15:0]   rd_data,
  input wire logic [15:0]   alarm_active,
  input wire logic [12:0]   chan_a_offset_value,
  input wire logic [12:0]   chan_b_offset_value
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  // Offset A write that should fire the load
  wire wa = wreq.wr && wreq.addr == DTM_OFFA_ADDR && auto_sync_en;
  // Suppression write, and the raw alarms as a flat word
  wire        wm    = wreq.wr && wreq.addr == DTM_SUPPRESS_ADDR;
  wire [15:0] raw_v = alarm_raw;
  sequence s_load;
    offset_sync ##1 chan_a_offset_value == $past(wreq.data[12:0], 2);
  endsequence
  chk_sync_load: assert property (wa |=> s_load)
    else $error("offset load missing");
  chk_sync_cause: assert property (!wa |=> !offset_sync)
    else $error("stray sync");
  chk_offs_hold: assert property (!offset_sync |=>
    $stable(chan_a_offset_value) && $stable(chan_b_offset_value))
    else $error("offset moved");
  chk_mask_gate: assert property (1 |=>
    (alarm_active & ~$past(alarm_raw)) == 16'h0000) else $error("gate");
  chk_mask_apply: assert property (wm |-> ##2
    alarm_active == ($past(raw_v) & ~$past(wreq.data, 2)
    & DTM_SUPPRESS_USED)) else $error("mask not applied");
  chk_unused_zero: assert property (
    (alarm_active & ~DTM_SUPPRESS_USED) == 16'h0000)
    else $error("unused alarm");
  chk_forced_copy: assert property (1 |=>
    output_forced == $past(alarm_raw.output_forced)) else $error("forced");
  chk_temp_low: assert property (rd_addr == DTM_TEMP_ADDR |=>
    rd_data[7:0] == 8'h00) else $error("temp low bits");
  chk_unmapped_zero: assert property (rd_addr > DTM_OFFB_ADDR |=>
    rd_data == 16'h0000) else $error("unmapped read");
endmodule
bind dtm_regs dtm_regs_monitor mon_u (.clock, .rst_b, .auto_sync_en,
  .offset_sync, .output_forced, .wreq, .alarm_raw, .rd_addr, .rd_data,
  .alarm_active, .chan_a_offset_value, .chan_b_offset_value);

// File: bench/dtm_host.sv
`timescale 1ns/1ps
// Host end of the register port; moves only on falling edges
module dtm_host
  import dtm_pkg::*;
(
  input  wire logic        clock,
  output dtm_wreq_type     wreq,
  output logic [6:0]       rd_addr,
  input  wire logic [15:0] rd_data
);
  initial
  begin
    wreq = '0;
    rd_addr = 7'h7f;
  end
  // Data inverted after the strobe so a stale word never looks valid
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(negedge clock) wreq = '{1'b1, a, d};
    @(negedge clock) wreq = '{1'b0, a, ~d};
  endtask
  // Read data is registered, so it is taken one edge later
  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    @(negedge clock) rd_addr = a;
    @(negedge clock) d = rd_data;
  endtask
endmodule

// File: bench/dac_temp_alarm_mask_offset_regs_test.sv
`timescale 1ns/1ps
module dac_temp_alarm_mask_offset_regs_test;
  import dtm_pkg::*;
  logic          clock = 1'b0, rst_b = 1'b0, auto_sync_en = 1'b0;
  logic [7:0]    temp_sensor = 8'he7;
  dtm_alarm_type alarm_raw = '0;
  dtm_wreq_type  wreq;
  logic [6:0]    rd_addr;
  logic [15:0]   rd_data, alarm_active, v;
  logic          forced, sync;
  logic [12:0]   off_a, off_b;
  logic [2:0]    foff;
  int            n_errors = 0, tests_run = 0;
  dtm_host host_u (.clock, .wreq, .rd_addr, .rd_data);
  dtm_regs dut_u (.clock, .rst_b, .wreq, .rd_addr, .temp_sensor,
    .auto_sync_en, .alarm_raw, .rd_data, .alarm_active,
    .output_forced(forced), .chan_a_offset_value(off_a),
    .chan_b_offset_value(off_b), .offset_sync(sync), .fifo_offset(foff));
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [6:0] a, input logic [15:0] exp);
    host_u.rd(a, v);
    cmp(v, exp);
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // 8 ns clock, and a watchdog that cuts a hang short
  initial forever #4 clock = ~clock;
  initial
  begin
    repeat (3000) @(posedge clock);
    n_errors++;
    conclude;
  end
  // Main sequence
  initial
  begin
    repeat (2) @(negedge clock);
    rst_b = 1'b1;
    rchk(DTM_SUPPRESS_ADDR, 16'hffff);
    rchk(DTM_OFFA_ADDR, 16'h0000);
    rchk(DTM_OFFB_ADDR, 16'h8000);
    cmp({13'h0, foff}, 16'h0004);
    repeat (DTM_TEMP_SCLK_CYC) @(negedge clock);
    rchk(DTM_TEMP_ADDR, 16'he700);
    host_u.wr(DTM_TEMP_ADDR, 16'h1234);
    rchk(DTM_TEMP_ADDR, 16'he700);
    $display("reset and temperature done");
    host_u.wr(DTM_SUPPRESS_ADDR, 16'hffff);
    rchk(DTM_SUPPRESS_ADDR, 16'hbfbe);
    host_u.wr(DTM_SUPPRESS_ADDR, 16'h0000);
    alarm_raw = '1;
    repeat (2) @(negedge clock);
    cmp(alarm_active, 16'hbfbe);
    cmp({15'h0, forced}, 16'h0001);
    host_u.wr(DTM_SUPPRESS_ADDR, 16'hffff);
    @(negedge clock);
    cmp(alarm_active, 16'h0000);
    alarm_raw = '0;
    @(negedge clock);
    cmp({15'h0, forced}, 16'h0000);
    rchk(7'h20, 16'h0000);
    $display("alarm mask done");
    host_u.wr(DTM_OFFB_ADDR, 16'h1234);
    host_u.wr(DTM_OFFA_ADDR, 16'hfabc);
    cmp({15'h0, sync}, 16'h0000);
    rchk(DTM_OFFA_ADDR, 16'h1abc);
    cmp({3'h0, off_b}, 16'h0000);
    auto_sync_en = 1'b1;
    host_u.wr(DTM_OFFA_ADDR, 16'h0005);
    cmp({15'h0, sync}, 16'h0001);
    repeat (2) @(negedge clock);
    cmp({3'h0, off_a}, 16'h0005);
    cmp({3'h0, off_b}, 16'h1234);
    cmp({15'h0, sync}, 16'h0000);
    rchk(DTM_OFFB_ADDR, 16'h1234);
    cmp({13'h0, foff}, 16'h0000);
    $display("offset load done");
    conclude;
  end
endmodule
